// file: src/pssd_pkg.sv
/*
 * shared constants for the product, shift and store datapath: register
 * offsets, field positions, reset values, opcodes and state codes.
 * assumes a 32-bit classic wishbone slave and a 16-bit data memory.
 */
package pssd_pkg;

    // ========================================================
    // widths
    localparam int DATA_W = 16;
    localparam int PROD_W = 32;
    localparam int OP_W   = 4;

    // ========================================================
    // register byte offsets
    localparam logic [7:0] ADR_OPND_ADDR = 8'h00;
    localparam logic [7:0] ADR_OPND_IMM  = 8'h04;
    localparam logic [7:0] ADR_EXEC      = 8'h08;
    localparam logic [7:0] ADR_ACC       = 8'h0c;
    localparam logic [7:0] ADR_PROD      = 8'h10;
    localparam logic [7:0] ADR_STATUS    = 8'h14;

    // ========================================================
    // field positions
    localparam int EXEC_OP_LSB   = 0;
    localparam int STAT_HOLD_BIT  = 0;
    localparam int STAT_OVF_BIT   = 1;
    localparam int STAT_SHIFT_LSB = 2;
    localparam int STAT_BUSY_BIT = 4;
    localparam int MMR_IDX_W     = 7;
    localparam int MMR_CLR_W     = 9;

    // ========================================================
    // reset values
    localparam logic        HOLD_RST  = 1'b0;
    localparam logic        OVF_RST   = 1'b0;
    localparam logic [1:0]  SHIFT_RST = 2'h0;
    localparam logic [31:0] WORD_RST = 32'h0;
    localparam logic [15:0] HALF_RST = 16'h0;

    // ========================================================
    // saturation limits and shift distances
    localparam logic [31:0] SAT_POS = 32'h7fffffff;
    localparam logic [31:0] SAT_NEG = 32'h80000000;
    localparam int SHL_SMALL = 1;
    localparam int SHL_BIG   = 4;
    localparam int SHR_AMT   = 6;

    typedef enum logic [1:0] {
        SHIFT_NONE   = 2'b00,
        SHIFT_LEFT1  = 2'b01,
        SHIFT_LEFT4  = 2'b10,
        SHIFT_RIGHT6 = 2'b11
    } pssd_shift_t;

    typedef enum logic [3:0] {
        OP_NOP       = 4'h0,
        OP_SET_HOLD  = 4'h1,
        OP_SET_OVF   = 4'h2,
        OP_CLR_OVF   = 4'h3,
        OP_SUB_PROD  = 4'h4,
        OP_ST_HIGH   = 4'h5,
        OP_ST_LOW    = 4'h6,
        OP_ST_IMM    = 4'h7,
        OP_SET_SHIFT = 4'h8,
        OP_ST_MAPPED = 4'h9
    } pssd_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_CAPT  = 2'b10,
        ST_WRITE = 2'b11
    } pssd_state_t;

endpackage

// file: src/pssd_core_if.sv
/*
 * carrier between the datapath and its status bits and product shifter.
 * assumes the datapath drives the commands and the product word.
 */
`timescale 1ns/1ps
`default_nettype none

interface pssd_core_if;
    logic        set_hold;
    logic        set_ovf;
    logic        clr_ovf;
    logic        load_shift;
    logic [1:0]  shift_imm;
    logic        hold_mode_bit;
    logic        overflow_mode_bit;
    logic [1:0]  product_shift_mode;
    logic [31:0] product;
    logic [31:0] product_shifted;

    modport status (
        input  set_hold, set_ovf, clr_ovf, load_shift, shift_imm,
        output hold_mode_bit, overflow_mode_bit, product_shift_mode
    );
    modport shifter (
        input  product, product_shift_mode,
        output product_shifted
    );
endinterface

`default_nettype wire

// file: src/pssd_status.sv
/*
 * hold mode, overflow mode and product shift mode status bits.
 * assumes at most one command is raised per cycle by the datapath.
 */
`timescale 1ns/1ps
`default_nettype none

module pssd_status
    import pssd_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    pssd_core_if.status st_if
);

    // ========================================================
    // status flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_if.hold_mode_bit      <= HOLD_RST;
            st_if.overflow_mode_bit  <= OVF_RST;
            st_if.product_shift_mode <= SHIFT_RST;
        end else begin
            if (st_if.set_hold) begin
                st_if.hold_mode_bit <= 1'b1;
            end
            if (st_if.set_ovf) begin
                st_if.overflow_mode_bit <= 1'b1;
            end else if (st_if.clr_ovf) begin
                st_if.overflow_mode_bit <= 1'b0;
            end
            if (st_if.load_shift) begin
                st_if.product_shift_mode <= st_if.shift_imm;
            end
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_hold_set: assert property (
        st_if.set_hold |=> st_if.hold_mode_bit [*2])
        else $error("hold mode bit not set");
    chk_ovf_set: assert property (
        st_if.set_ovf |=> st_if.overflow_mode_bit)
        else $error("overflow mode bit not set");
    chk_ovf_clr: assert property (
        st_if.clr_ovf && !st_if.set_ovf |=> !st_if.overflow_mode_bit)
        else $error("overflow mode bit not cleared");
    chk_shift_load: assert property (
        st_if.load_shift
        |=> st_if.product_shift_mode == $past(st_if.shift_imm))
        else $error("shift mode not loaded");

endmodule

`default_nettype wire

// file: src/pssd_shifter.sv
/*
 * product output shifter, the four shift mode options.
 * assumes a 32-bit product; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module pssd_shifter
    import pssd_pkg::*;
(
    pssd_core_if.shifter sh_if
);

    // ========================================================
    // shift select; the right shift keeps the sign so small
    // negative products stay negative after scaling
    always_comb begin
        case (pssd_shift_t'(sh_if.product_shift_mode))
            SHIFT_NONE:   sh_if.product_shifted = sh_if.product;
            SHIFT_LEFT1:  sh_if.product_shifted =
                              sh_if.product << SHL_SMALL;
            SHIFT_LEFT4:  sh_if.product_shifted =
                              sh_if.product << SHL_BIG;
            SHIFT_RIGHT6: sh_if.product_shifted =
                              $signed(sh_if.product) >>> SHR_AMT;
            default:      sh_if.product_shifted = sh_if.product;
        endcase
    end

endmodule

`default_nettype wire

// file: src/pssd_datapath.sv
/*
 * product, shift and store datapath: executes the status, product and
 * store instructions issued through a wishbone register file and writes
 * results to a 16-bit data memory port.
 * assumes the data memory returns read data one cycle after its read
 * strobe and accepts a write in the cycle its write strobe is high.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - the set hold mode instruction forces the hold mode bit to 1.
// - storing a mapped register reads it at the 7 low address bits and writes it to the long immediate address.
// - the mapped register source address has its upper 9 bits cleared whatever page or pointer bits hold.
// - set overflow mode sets the overflow mode bit to 1 and the clear instruction clears it.
// - subtract product takes the shifted product away from the accumulator and keeps the result there.
// - store product high writes the upper half of the shifted product to the addressed location.
// - store product low writes the lower half of the shifted product to the addressed location.
// - store long immediate writes the full 16-bit pattern to memory and leaves the accumulator alone.
// - set product shift mode copies its 2-bit operand into the shift mode field.
// - mode 00 passes the product, 01 shifts it left by one and 10 left by four, zero filled.
// - mode 11 shifts the product right by six with sign extension, losing the low six bits.
module pssd_datapath
    import pssd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [15:0] dmem_addr_o,
    output logic      [15:0] dmem_wdata_o,
    output logic             dmem_we_o,
    output logic             dmem_re_o,
    input  wire logic [15:0] dmem_rdata_i,
    output logic             hold_mode_o,
    output logic             overflow_mode_o,
    output logic      [1:0]  product_shift_mode_o
);

    // ========================================================
    // declarations
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] wmask;
    logic [15:0] opnd_addr_reg;
    logic [15:0] opnd_imm_reg;
    logic [31:0] acc_reg;
    logic [31:0] prod_reg;
    logic [3:0]  op_reg;
    logic [15:0] mem_addr_reg;
    logic [15:0] mem_data_reg;
    logic [31:0] status_word;
    logic [31:0] sub_res;
    logic [15:0] store_data;
    pssd_state_t state_reg;
    pssd_state_t state_next;

    pssd_core_if core_if ();

    // ========================================================
    // wishbone decode
    wire bus_req  = wb_cyc_i & wb_stb_i;
    // a write lands at the edge where ack is seen high
    wire wr_take  = bus_req & wb_we_i & ack_reg;
    wire sel_addr = (wb_adr_i == ADR_OPND_ADDR);
    wire sel_imm  = (wb_adr_i == ADR_OPND_IMM);
    wire sel_exec = (wb_adr_i == ADR_EXEC);
    wire sel_acc  = (wb_adr_i == ADR_ACC);
    wire sel_prod = (wb_adr_i == ADR_PROD);
    wire sel_stat = (wb_adr_i == ADR_STATUS);
    wire busy     = (state_reg != ST_IDLE);

    // byte lane masks from the select lines
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
        end
    endgenerate

    // ========================================================
    // instruction decode; a new instruction while a store is
    // still in flight is dropped, software polls the busy bit
    wire      exec_go = wr_take & sel_exec & wb_sel_i[0] & ~busy;
    pssd_op_t exec_op;
    assign exec_op = pssd_op_t'(wb_dat_i[EXEC_OP_LSB +: OP_W]);

    wire go_hold      = exec_go & (exec_op == OP_SET_HOLD);
    wire go_set_ovf   = exec_go & (exec_op == OP_SET_OVF);
    wire go_clr_ovf   = exec_go & (exec_op == OP_CLR_OVF);
    wire go_sub       = exec_go & (exec_op == OP_SUB_PROD);
    wire go_st_high   = exec_go & (exec_op == OP_ST_HIGH);
    wire go_st_low    = exec_go & (exec_op == OP_ST_LOW);
    wire go_st_imm    = exec_go & (exec_op == OP_ST_IMM);
    wire go_set_shift = exec_go & (exec_op == OP_SET_SHIFT);
    wire go_st_mapped = exec_go & (exec_op == OP_ST_MAPPED);
    wire go_store     = go_st_high | go_st_low | go_st_imm;

    // operands are frozen while a store runs so the target holds
    wire opnd_wr = wr_take & ~busy;

    // ========================================================
    // status bits and product shifter
    assign core_if.set_hold   = go_hold;
    assign core_if.set_ovf    = go_set_ovf;
    assign core_if.clr_ovf    = go_clr_ovf;
    assign core_if.load_shift = go_set_shift;
    // the shift mode operand always comes from the immediate register
    assign core_if.shift_imm  = opnd_imm_reg[1:0];
    assign core_if.product  = prod_reg;

    pssd_status u_status (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .st_if (core_if.status)
    );

    pssd_shifter u_shifter (
        .sh_if (core_if.shifter)
    );

    wire [31:0] shifted = core_if.product_shifted;
    wire        sat_en  = core_if.overflow_mode_bit;

    // ========================================================
    // subtract product; saturates only in overflow mode
    wire [32:0] diff = {acc_reg[31], acc_reg} - {shifted[31], shifted};
    wire        ovf  = diff[32] ^ diff[31];
    assign sub_res = (sat_en & ovf) ? (diff[32] ? SAT_NEG : SAT_POS)
                                    : diff[31:0];

    // ========================================================
    // store data select, high or low half of the shifted product, or the immediate register
    assign store_data = go_st_high ? shifted[31:16] :
                        go_st_low  ? shifted[15:0]  :
                                  opnd_imm_reg;

    // mapped register source: upper address bits forced to zero
    wire [15:0] mmr_src = {{MMR_CLR_W{1'b0}},
                           opnd_addr_reg[MMR_IDX_W-1:0]};

    // ========================================================
    // store sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (go_st_mapped) begin
                    state_next = ST_READ;
                end else if (go_store) begin
                    state_next = ST_WRITE;
                end
            end
            ST_READ:  state_next = ST_CAPT;
            ST_CAPT:  state_next = ST_WRITE;
            ST_WRITE: state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // memory address and data flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_reg <= HALF_RST;
            mem_data_reg <= HALF_RST;
        end else if (go_st_mapped) begin
            mem_addr_reg <= mmr_src;
        end else if (go_store) begin
            mem_addr_reg <= opnd_addr_reg;
            mem_data_reg <= store_data;
        end else if (state_reg == ST_CAPT) begin
            mem_addr_reg <= opnd_imm_reg;
            mem_data_reg <= dmem_rdata_i;
        end
    end

    assign dmem_re_o    = (state_reg == ST_READ);
    assign dmem_we_o    = (state_reg == ST_WRITE);
    assign dmem_addr_o  = mem_addr_reg;
    assign dmem_wdata_o = mem_data_reg;

    // ========================================================
    // operand registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opnd_addr_reg <= HALF_RST;
            opnd_imm_reg  <= HALF_RST;
        end else if (opnd_wr & sel_addr) begin
            opnd_addr_reg <= (opnd_addr_reg & ~wmask[15:0])
                           | (wb_dat_i[15:0] & wmask[15:0]);
        end else if (opnd_wr & sel_imm) begin
            opnd_imm_reg <= (opnd_imm_reg & ~wmask[15:0])
                          | (wb_dat_i[15:0] & wmask[15:0]);
        end
    end

    // accumulator: the long immediate store never touches it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= WORD_RST;
        end else if (go_sub) begin
            acc_reg <= sub_res;
        end else if (wr_take & sel_acc) begin
            acc_reg <= (acc_reg & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // product register, loaded by software in this slice
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prod_reg <= WORD_RST;
        end else if (wr_take & sel_prod) begin
            prod_reg <= (prod_reg & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // last accepted opcode, for readback
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg <= OP_NOP;
        end else if (exec_go) begin
            op_reg <= exec_op;
        end
    end

    // ========================================================
    // readback
    always_comb begin
        status_word = WORD_RST;
        status_word[STAT_HOLD_BIT]       = core_if.hold_mode_bit;
        status_word[STAT_OVF_BIT]        = sat_en;
        status_word[STAT_SHIFT_LSB +: 2] = core_if.product_shift_mode;
        status_word[STAT_BUSY_BIT]       = busy;
    end

    wire [31:0] rd_mux =
        sel_addr ? {16'h0, opnd_addr_reg} :
        sel_imm  ? {16'h0, opnd_imm_reg}  :
        sel_exec ? {28'h0, op_reg}        :
        sel_acc  ? acc_reg                :
        sel_prod ? prod_reg               :
        sel_stat ? status_word            :
                   WORD_RST;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= WORD_RST;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req & ~ack_reg) begin
                rdat_reg <= rd_mux;
            end
        end
    end

    assign wb_ack_o             = ack_reg;
    assign wb_dat_o             = rdat_reg;
    assign hold_mode_o          = core_if.hold_mode_bit;
    assign overflow_mode_o      = sat_en;
    assign product_shift_mode_o = core_if.product_shift_mode;

    // ========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_mmr_read;
        dmem_re_o && dmem_addr_o[15:MMR_IDX_W] == 9'h0;
    endsequence

    sequence s_mmr_write;
        dmem_we_o && dmem_addr_o == opnd_imm_reg
        && dmem_wdata_o == $past(dmem_rdata_i);
    endsequence

    chk_shift_none: assert property (
        product_shift_mode_o == SHIFT_NONE |-> shifted == prod_reg)
        else $error("mode 00 product altered");
    chk_shift_left: assert property (
        product_shift_mode_o == SHIFT_LEFT1
        |-> shifted == {prod_reg[30:0], 1'b0})
        else $error("mode 01 shift wrong");
    chk_shift_four: assert property (
        product_shift_mode_o == SHIFT_LEFT4
        |-> shifted == {prod_reg[27:0], 4'h0})
        else $error("mode 10 shift wrong");
    chk_shift_right: assert property (
        product_shift_mode_o == SHIFT_RIGHT6
        |-> shifted == {{6{prod_reg[31]}}, prod_reg[31:6]})
        else $error("mode 11 shift wrong");
    chk_subtract_product_instr_acc: assert property (
        go_sub && !sat_en
        |=> acc_reg == $past(acc_reg) - $past(shifted))
        else $error("subtract product result wrong");
    chk_high_store: assert property (
        go_st_high |=> dmem_we_o && dmem_wdata_o == $past(shifted[31:16])
        && dmem_addr_o == $past(opnd_addr_reg))
        else $error("high product store wrong");
    chk_low_store: assert property (
        go_st_low |=> dmem_we_o && dmem_wdata_o == $past(shifted[15:0]))
        else $error("low product store wrong");
    chk_imm_store: assert property (
        go_st_imm |=> dmem_we_o && $stable(acc_reg)
        && dmem_wdata_o == $past(opnd_imm_reg))
        else $error("long immediate store wrong");
    chk_mmr_flow: assert property (
        go_st_mapped |=> s_mmr_read ##2 s_mmr_write)
        else $error("mapped register store sequence wrong");
    chk_mmr_index: assert property (
        go_st_mapped |=> dmem_addr_o[MMR_IDX_W-1:0]
        == $past(opnd_addr_reg[MMR_IDX_W-1:0]))
        else $error("mapped register index wrong");

endmodule

`default_nettype wire

// file: tb/pssd_datapath_tb.sv
/*
 * self-checking bench for the product, shift and store datapath.
 * assumes the design package is compiled first; bench acts as bus master
 * and as a one-cycle data memory.
 */
`timescale 1ns/1ps
`default_nettype none

module pssd_datapath_tb
    import pssd_pkg::*;
;
    // ========================================================
    // signals
    logic        clk_i        = 1'b0;
    logic        rst_i        = 1'b1;
    logic        wb_cyc       = 1'b0;
    logic        wb_stb       = 1'b0;
    logic        wb_we        = 1'b0;
    logic [7:0]  wb_adr       = 8'h00;
    logic [31:0] wb_dat       = 32'h0;
    logic [3:0]  wb_sel       = 4'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [15:0] dmem_addr_o;
    logic [15:0] dmem_wdata_o;
    logic        dmem_we_o;
    logic        dmem_re_o;
    logic [15:0] dmem_rdata_i = 16'h0;
    logic        hold_mode_o;
    logic        overflow_mode_o;
    logic [1:0]  shift_mode_o;
    logic [15:0] mem_val      = 16'hbeef;
    logic [15:0] wr_addr      = 16'h0;
    logic [15:0] wr_data      = 16'h0;
    logic [15:0] rd_addr      = 16'h0;
    int          wr_n         = 0;
    int          wr_base      = 0;
    int          errors       = 0;
    int          n_compared   = 0;
    logic [31:0] q;
    logic [31:0] p;

    pssd_datapath dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .dmem_addr_o(dmem_addr_o), .dmem_wdata_o(dmem_wdata_o),
        .dmem_we_o(dmem_we_o), .dmem_re_o(dmem_re_o),
        .dmem_rdata_i(dmem_rdata_i), .hold_mode_o(hold_mode_o),
        .overflow_mode_o(overflow_mode_o),
        .product_shift_mode_o(shift_mode_o)
    );

    // ========================================================
    // clock, memory model and store monitor
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // read data valid one cycle after the strobe, else a toggling pattern
    // so a late sample never looks right by chance
    always @(posedge clk_i) begin
        dmem_rdata_i <= (dmem_re_o === 1'b1) ? mem_val : ~dmem_rdata_i;
        if (dmem_re_o === 1'b1) rd_addr <= dmem_addr_o;
        if (dmem_we_o === 1'b1) begin
            wr_n    <= wr_n + 1;
            wr_addr <= dmem_addr_o;
            wr_data <= dmem_wdata_o;
        end
    end

    // ========================================================
    // tasks
    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        if (n >= 50) begin
            errors++;
            $display("Error bus ack expected 1 seen %b", wb_ack_o);
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, a, d, r);
    endtask

    task automatic wb_rd(input logic [7:0] a, output logic [31:0] r);
        wb_xfer(1'b0, a, 32'h0, r);
    endtask

    // issue an opcode and poll busy until the instruction is finished
    task automatic run_op(input pssd_op_t op);
        logic [31:0] r;
        int n;
        n = 0;
        // the store monitor owns wr_n; keep a base to count from
        wr_base = wr_n;
        wb_wr(ADR_EXEC, {28'h0, op});
        do begin
            wb_rd(ADR_STATUS, r);
            n++;
        end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            $display("Error busy expected 0 seen %b", r[STAT_BUSY_BIT]);
        end
    endtask

    task automatic check_word(input string nm, input logic [31:0] e,
                              input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic check_wr(input string nm, input logic [15:0] ea,
                            input logic [15:0] ed);
        n_compared++;
        if (wr_n - wr_base !== 1 || wr_addr !== ea || wr_data !== ed) begin
            errors++;
            $display("Error %s expected 1 %h %h seen %0d %h %h",
                     nm, ea, ed, wr_n - wr_base, wr_addr, wr_data);
        end
    endtask

    function automatic logic [31:0] exp_shift(input logic [31:0] v,
                                              input logic [1:0] m);
        case (m)
            2'b00:   return v;
            2'b01:   return v << 1;
            2'b10:   return v << 4;
            default: return $signed(v) >>> 6;
        endcase
    endfunction

    // ========================================================
    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        complete_run();
    end

    // ========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb_rd(ADR_STATUS, q);
        check_word("status at reset", 32'h0, q);
        run_op(OP_SET_HOLD);
        check_word("hold mode", 32'h1, {31'h0, hold_mode_o});
        run_op(OP_SET_OVF);
        check_word("ovf set", 32'h1, {31'h0, overflow_mode_o});
        run_op(OP_CLR_OVF);
        check_word("ovf clear", 32'h0, {31'h0, overflow_mode_o});
        // every shift mode, negative product to show sign extension
        p = 32'h8123_4567;
        for (int m = 0; m < 4; m++) begin
            wb_wr(ADR_OPND_IMM, m);
            run_op(OP_SET_SHIFT);
            check_word("shift mode", m, {30'h0, shift_mode_o});
            wb_wr(ADR_PROD, p);
            wb_wr(ADR_OPND_ADDR, 32'h0100 + m);
            run_op(OP_ST_HIGH);
            q = exp_shift(p, m[1:0]);
            check_wr("high store", 16'h0100 + m, q[31:16]);
            run_op(OP_ST_LOW);
            check_wr("low store", 16'h0100 + m, q[15:0]);
            wb_wr(ADR_ACC, 32'h1234_0000);
            run_op(OP_SUB_PROD);
            q = 32'h1234_0000 - exp_shift(p, m[1:0]);
            wb_rd(ADR_ACC, p);
            check_word("acc minus prod", q, p);
            p = 32'h8123_4567;
        end
        // long immediate store leaves the accumulator alone
        wb_wr(ADR_ACC, 32'h1111_2222);
        wb_wr(ADR_OPND_ADDR, 32'h0200);
        wb_wr(ADR_OPND_IMM, 32'ha5c3);
        run_op(OP_ST_IMM);
        check_wr("long imm store", 16'h0200, 16'ha5c3);
        wb_rd(ADR_ACC, q);
        check_word("acc kept", 32'h1111_2222, q);
        // mapped register store with page bits set in the source address
        wb_wr(ADR_OPND_ADDR, 32'hfe85);
        wb_wr(ADR_OPND_IMM, 32'h0300);
        run_op(OP_ST_MAPPED);
        check_word("mapped source", 32'h0005, {16'h0, rd_addr});
        check_wr("mapped store", 16'h0300, mem_val);
        // saturation once overflow mode is on
        run_op(OP_SET_OVF);
        wb_wr(ADR_OPND_IMM, 32'h0);
        run_op(OP_SET_SHIFT);
        wb_wr(ADR_ACC, 32'h8000_0000);
        wb_wr(ADR_PROD, 32'h0000_0001);
        run_op(OP_SUB_PROD);
        wb_rd(ADR_ACC, q);
        check_word("saturated acc", SAT_NEG, q);
        wb_rd(8'h20, q);
        check_word("unmapped read", 32'h0, q);
        complete_run();
    end
endmodule

`default_nettype wire
